// *** rtl/ctirq_pkg.sv ***
/*
 package for the core tick timer and interrupt pending block:
 register offsets, field positions, reset values and carrier structs.
 assumes a 32-bit apb slave decoding the low eight address bits.
*/
`default_nettype none
package ctirq_pkg;

    localparam int unsigned NUM_IRQ = 29;
    localparam int unsigned PRIO_W = 3;
    localparam int unsigned NUM_W = 5;
    localparam int unsigned TICK_W = 24;
    localparam int unsigned SPLIT_W = 2;

    localparam logic [7:0] OFS_TICK_CTRL = 8'h00;
    localparam logic [7:0] OFS_TICK_RELOAD = 8'h04;
    localparam logic [7:0] OFS_TICK_CURRENT = 8'h08;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] OFS_SET_PEND = 8'h14;
    localparam logic [7:0] OFS_CLR_PEND = 8'h18;
    localparam logic [7:0] OFS_ACTIVE = 8'h1C;
    localparam logic [7:0] OFS_LEVEL_SEL = 8'h20;
    localparam logic [7:0] OFS_SW_TRIG = 8'h24;
    localparam logic [7:0] OFS_PRIO_GROUP = 8'h28;
    localparam logic [7:0] OFS_SELECT = 8'h2C;
    localparam logic [3:0] OFS_PRIO_PAGE = 4'h4;

    localparam int unsigned PRIO_WORDS = 4;
    localparam int unsigned PRIO_PER_WORD = 8;
    localparam int unsigned PRIO_FIELD = 4;

    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned CTRL_INTEN_BIT = 1;
    localparam int unsigned CTRL_CLKSRC_BIT = 2;
    localparam int unsigned CTRL_COUNT_BIT = 16;
    localparam int unsigned SEL_NUM_LSB = 0;
    localparam int unsigned SEL_PRIO_LSB = 8;
    localparam int unsigned SEL_VALID_BIT = 31;

    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [23:0] RELOAD_RST = 24'h000000;
    localparam logic [28:0] ENABLE_RST = 29'h00000000;
    localparam logic [28:0] LEVEL_SEL_RST = 29'h1FFFFFFF;
    localparam logic [2:0] PRIO_RST = 3'h0;
    localparam logic [1:0] SPLIT_RST = 2'h0;

    typedef struct packed {
        logic enable;
        logic inten;
        logic clksrc;
        logic [TICK_W-1:0] reload;
    } ctirq_tick_cfg_t;

    typedef struct packed {
        logic cur_wr;
        logic ctrl_rd;
    } ctirq_tick_acc_t;

    typedef struct packed {
        logic [TICK_W-1:0] current;
        logic count_flag;
        logic wrap_event;
    } ctirq_tick_stat_t;

    typedef struct packed {
        logic valid;
        logic [NUM_W-1:0] num;
        logic [PRIO_W-1:0] prio;
    } ctirq_pick_t;

endpackage
`default_nettype wire

// *** rtl/ctirq_tick.sv ***
/*
 core tick timer: 24-bit down-counter with reload, zero flag and event.
 assumes config and access strobes arrive from the apb slave on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module ctirq_tick
(
    input wire logic pclk,
    input wire logic presetn,
    input wire ctirq_pkg::ctirq_tick_cfg_t cfg,
    input wire ctirq_pkg::ctirq_tick_acc_t acc,
    input wire logic dbg_halt,
    input wire logic ref_tick,
    output ctirq_pkg::ctirq_tick_stat_t stat
);

    logic ref_s1_r;
    logic ref_s2_r;
    logic ref_s3_r;
    logic ref_lvl_r;
    logic [ctirq_pkg::TICK_W-1:0] cur_r;
    logic [ctirq_pkg::TICK_W-1:0] cur_nxt;
    logic flag_r;
    logic flag_nxt;
    logic event_r;
    wire ref_agree;
    wire ref_rise;
    wire step;
    wire at_zero;
    wire hit;

    // change accepted only once stages two and three agree
    assign ref_agree = (ref_s2_r == ref_s3_r);
    assign ref_rise = ref_agree & ref_s2_r & ~ref_lvl_r;

    // debug halt freezes the count; stopped pclk holds it too
    assign step = cfg.enable & ~dbg_halt
        & (cfg.clksrc | ref_rise);
    assign at_zero = (cur_r == {ctirq_pkg::TICK_W{1'b0}});
    // write to current value masks the hit, so no exception
    assign hit = step & ~acc.cur_wr
        & (cur_r == {{(ctirq_pkg::TICK_W-1){1'b0}}, 1'b1});

    // zero reload keeps the counter parked at zero
    assign cur_nxt = acc.cur_wr ? {ctirq_pkg::TICK_W{1'b0}}
        : ~step ? cur_r
        : at_zero ? cfg.reload
        : cur_r - {{(ctirq_pkg::TICK_W-1){1'b0}}, 1'b1};

    // set beats the read clear
    assign flag_nxt = hit ? 1'b1
        : (acc.cur_wr | acc.ctrl_rd) ? 1'b0
        : flag_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ref_s1_r <= 1'b0;
            ref_s2_r <= 1'b0;
            ref_s3_r <= 1'b0;
            ref_lvl_r <= 1'b0;
            cur_r <= {ctirq_pkg::TICK_W{1'b0}};
            flag_r <= 1'b0;
            event_r <= 1'b0;
        end
        else
        begin
            ref_s1_r <= ref_tick;
            ref_s2_r <= ref_s1_r;
            ref_s3_r <= ref_s2_r;
            ref_lvl_r <= ref_agree ? ref_s2_r : ref_lvl_r;
            cur_r <= cur_nxt;
            flag_r <= flag_nxt;
            event_r <= hit;
        end
    end

    assign stat.current = cur_r;
    assign stat.count_flag = flag_r;
    assign stat.wrap_event = event_r;

endmodule
`default_nettype wire

// *** rtl/ctirq_top.sv ***
/*
 apb register slave, interrupt pending/active tracking and the
 priority selection for 29 lines, plus the core tick timer.
 assumes interrupt lines and handler strobes are synchronous to pclk.
*/
//
// Contract
// - tick counter 24-bit, write clears, wraps
// - decrement per clock, reload after zero
// - zero reload stops counting at wrap
// - zero sets flag, control read clears
// - current write clears, no exception
// - current read returns live counter
// - counter on system clock, holds gated
// - no decrement while debugger halts
// - control: source, enable, irq enable, flag
// - 29 lines, priority 0-7, zero highest
// - group/sub split, priorities change live
// - pulses sampled on rising pclk edge
// - high line while not active pends
// - rising edge on line pends
// - set-pending or trigger write pends
// - handler entry moves pending to active
// - level return: line high repends
// - pulse in handler: active and pending
// - level clear ignored while line high
// - pulse clear: drops pending only
`timescale 1ns/1ps
`default_nettype none
module ctirq_top
#(
    parameter int unsigned ADDR_W = 12
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [ctirq_pkg::NUM_IRQ-1:0] irq_line,
    input wire logic dbg_halt,
    input wire logic ref_tick,
    input wire logic handler_enter,
    input wire logic handler_return,
    input wire logic [ctirq_pkg::NUM_W-1:0] handler_num,
    output logic irq_req,
    output logic [ctirq_pkg::NUM_W-1:0] irq_req_num,
    output logic [ctirq_pkg::PRIO_W-1:0] irq_req_prio,
    output logic tick_exc_req
);

    localparam int unsigned N = ctirq_pkg::NUM_IRQ;

    logic [2:0] ctrl_r;
    logic [ctirq_pkg::TICK_W-1:0] reload_r;
    logic [N-1:0] enable_r;
    logic [N-1:0] level_r;
    logic [N-1:0] pend_r;
    logic [N-1:0] act_r;
    logic [N-1:0] line_prev_r;
    logic [N-1:0] pend_nxt;
    logic [N-1:0] act_nxt;
    logic [N-1:0][ctirq_pkg::PRIO_W-1:0] prio_r;
    logic [N-1:0][ctirq_pkg::PRIO_W-1:0] prio_nxt;
    logic [ctirq_pkg::SPLIT_W-1:0] split_r;
    logic [31:0] prdata_r;
    logic irq_req_r;
    logic [ctirq_pkg::NUM_W-1:0] irq_num_r;
    logic [ctirq_pkg::PRIO_W-1:0] irq_prio_r;
    logic tick_exc_r;
    logic [31:0][3:0] prio_nib;
    logic [ctirq_pkg::PRIO_WORDS-1:0][31:0] prio_word;

    ctirq_pkg::ctirq_tick_cfg_t tick_cfg;
    ctirq_pkg::ctirq_tick_acc_t tick_acc;
    ctirq_pkg::ctirq_tick_stat_t tick_stat;
    ctirq_pkg::ctirq_pick_t cand;
    ctirq_pkg::ctirq_pick_t running;

    wire [7:0] addr;
    wire addr_hi_ok;
    wire setup;
    wire access;
    wire wr;
    wire hit_ctrl;
    wire hit_reload;
    wire hit_cur;
    wire hit_en;
    wire hit_set;
    wire hit_clr;
    wire hit_act;
    wire hit_lvl;
    wire hit_trig;
    wire hit_split;
    wire hit_sel;
    wire hit_prio;
    wire mapped;
    wire [31:0] rd_mux;
    wire [31:0] sel_word;
    wire [N-1:0] trig_bits;
    wire [N-1:0] enter_bits;
    wire [N-1:0] ret_bits;
    wire preempt;

    // one-hot decode of an interrupt number
    function automatic logic [N-1:0] onehot
    (
        input logic [ctirq_pkg::NUM_W-1:0] num
    );
        logic [N-1:0] r;
        r = '0;
        for (int i = 0; i < N; i++)
        begin
            if (num == ctirq_pkg::NUM_W'(i))
            begin
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction

    // strict compare keeps the lowest number on a tie
    function automatic ctirq_pkg::ctirq_pick_t pick
    (
        input logic [N-1:0] mask,
        input logic [N-1:0][ctirq_pkg::PRIO_W-1:0] pr
    );
        ctirq_pkg::ctirq_pick_t r;
        r = '0;
        for (int i = 0; i < N; i++)
        begin
            if (mask[i] && (!r.valid || pr[i] < r.prio))
            begin
                r.valid = 1'b1;
                r.num = ctirq_pkg::NUM_W'(i);
                r.prio = pr[i];
            end
        end
        return r;
    endfunction

    // low split bits are subpriority, the rest group priority
    function automatic logic [ctirq_pkg::PRIO_W-1:0] grp
    (
        input logic [ctirq_pkg::PRIO_W-1:0] p,
        input logic [ctirq_pkg::SPLIT_W-1:0] s
    );
        return ctirq_pkg::PRIO_W'(p >> s);
    endfunction

    // unaligned or out-of-page addresses answer with an error
    assign addr = paddr[7:0];
    assign addr_hi_ok = (paddr[ADDR_W-1:8] == '0)
        & (paddr[1:0] == 2'h0);
    assign setup = psel & ~penable;
    assign access = psel & penable;

    assign hit_ctrl = addr_hi_ok & (addr == ctirq_pkg::OFS_TICK_CTRL);
    assign hit_reload = addr_hi_ok & (addr == ctirq_pkg::OFS_TICK_RELOAD);
    assign hit_cur = addr_hi_ok & (addr == ctirq_pkg::OFS_TICK_CURRENT);
    assign hit_en = addr_hi_ok & (addr == ctirq_pkg::OFS_IRQ_ENABLE);
    assign hit_set = addr_hi_ok & (addr == ctirq_pkg::OFS_SET_PEND);
    assign hit_clr = addr_hi_ok & (addr == ctirq_pkg::OFS_CLR_PEND);
    assign hit_act = addr_hi_ok & (addr == ctirq_pkg::OFS_ACTIVE);
    assign hit_lvl = addr_hi_ok & (addr == ctirq_pkg::OFS_LEVEL_SEL);
    assign hit_trig = addr_hi_ok & (addr == ctirq_pkg::OFS_SW_TRIG);
    assign hit_split = addr_hi_ok & (addr == ctirq_pkg::OFS_PRIO_GROUP);
    assign hit_sel = addr_hi_ok & (addr == ctirq_pkg::OFS_SELECT);
    assign hit_prio = addr_hi_ok & (addr[7:4] == ctirq_pkg::OFS_PRIO_PAGE);
    assign mapped = hit_ctrl | hit_reload | hit_cur | hit_en | hit_set
        | hit_clr | hit_act | hit_lvl | hit_trig | hit_split | hit_sel
        | hit_prio;
    assign wr = access & pwrite & mapped;

    // zero wait states: every access phase completes at once
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata = prdata_r;

    assign tick_cfg.enable = ctrl_r[ctirq_pkg::CTRL_EN_BIT];
    assign tick_cfg.inten = ctrl_r[ctirq_pkg::CTRL_INTEN_BIT];
    assign tick_cfg.clksrc = ctrl_r[ctirq_pkg::CTRL_CLKSRC_BIT];
    assign tick_cfg.reload = reload_r;
    // flag clears in the setup cycle, after its value is captured
    assign tick_acc.ctrl_rd = setup & ~pwrite & hit_ctrl;
    assign tick_acc.cur_wr = wr & hit_cur;

    ctirq_tick u_tick
    (
        .pclk(pclk),
        .presetn(presetn),
        .cfg(tick_cfg),
        .acc(tick_acc),
        .dbg_halt(dbg_halt),
        .ref_tick(ref_tick),
        .stat(tick_stat)
    );

    assign trig_bits = (wr & hit_trig)
        ? onehot(pwdata[ctirq_pkg::NUM_W-1:0]) : '0;
    assign enter_bits = handler_enter ? onehot(handler_num) : '0;
    assign ret_bits = handler_return ? onehot(handler_num) : '0;

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++)
        begin : g_irq
            wire rise;
            wire hw_set;
            wire sw_set;
            wire sw_clr;
            // lines sampled on pclk; previous sample gives the edge
            assign rise = irq_line[gi] & ~line_prev_r[gi];
            // level lines rely on the peripheral holding until served
            assign hw_set = level_r[gi]
                ? (irq_line[gi] & ~act_r[gi] & ~enter_bits[gi])
                : rise;
            assign sw_set = (wr & hit_set & pwdata[gi])
                | trig_bits[gi];
            assign sw_clr = wr & hit_clr & pwdata[gi]
                & ~(level_r[gi] & irq_line[gi]);
            // hardware and software set both beat any clear
            assign pend_nxt[gi] = (hw_set | sw_set) ? 1'b1
                : enter_bits[gi] ? 1'b0
                : (ret_bits[gi] & level_r[gi]) ? irq_line[gi]
                : sw_clr ? 1'b0
                : pend_r[gi];
            assign act_nxt[gi] = enter_bits[gi] ? 1'b1
                : ret_bits[gi] ? 1'b0
                : act_r[gi];
            assign prio_nxt[gi] = (wr & hit_prio
                & (addr[3:2] == 2'(gi / ctirq_pkg::PRIO_PER_WORD)))
                ? pwdata[(gi % ctirq_pkg::PRIO_PER_WORD)
                    * ctirq_pkg::PRIO_FIELD +: ctirq_pkg::PRIO_W]
                : prio_r[gi];
        end
        for (gi = 0; gi < 32; gi++)
        begin : g_nib
            if (gi < N)
            begin : g_used
                assign prio_nib[gi] = {1'b0, prio_r[gi]};
            end
            else
            begin : g_pad
                assign prio_nib[gi] = 4'h0;
            end
        end
        for (gi = 0; gi < ctirq_pkg::PRIO_WORDS; gi++)
        begin : g_word
            assign prio_word[gi] = prio_nib[gi*8 +: 8];
        end
    endgenerate

    assign cand = pick(pend_r & enable_r & ~act_r, prio_r);
    assign running = pick(act_r, prio_r);
    // only a strictly higher group priority may preempt a handler
    assign preempt = cand.valid & (~running.valid
        | (grp(cand.prio, split_r) < grp(running.prio, split_r)));

    assign sel_word = {irq_req_r, 15'h0000, 5'h00, irq_prio_r,
        3'h0, irq_num_r};

    assign rd_mux = hit_ctrl ? {15'h0000, tick_stat.count_flag,
            13'h0000, ctrl_r}
        : hit_reload ? {8'h00, reload_r}
        : hit_cur ? {8'h00, tick_stat.current}
        : hit_en ? {3'h0, enable_r}
        : (hit_set | hit_clr) ? {3'h0, pend_r}
        : hit_act ? {3'h0, act_r}
        : hit_lvl ? {3'h0, level_r}
        : hit_split ? {30'h00000000, split_r}
        : hit_sel ? sel_word
        : hit_prio ? prio_word[addr[3:2]]
        : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= ctirq_pkg::CTRL_RST;
            reload_r <= ctirq_pkg::RELOAD_RST;
            enable_r <= ctirq_pkg::ENABLE_RST;
            level_r <= ctirq_pkg::LEVEL_SEL_RST;
            split_r <= ctirq_pkg::SPLIT_RST;
            prdata_r <= 32'h00000000;
        end
        else
        begin
            ctrl_r <= (wr & hit_ctrl) ? pwdata[2:0] : ctrl_r;
            reload_r <= (wr & hit_reload)
                ? pwdata[ctirq_pkg::TICK_W-1:0] : reload_r;
            enable_r <= (wr & hit_en) ? pwdata[N-1:0] : enable_r;
            level_r <= (wr & hit_lvl) ? pwdata[N-1:0] : level_r;
            split_r <= (wr & hit_split)
                ? pwdata[ctirq_pkg::SPLIT_W-1:0] : split_r;
            prdata_r <= (setup & ~pwrite) ? rd_mux : prdata_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend_r <= '0;
            act_r <= '0;
            line_prev_r <= '0;
            prio_r <= {N{ctirq_pkg::PRIO_RST}};
        end
        else
        begin
            pend_r <= pend_nxt;
            act_r <= act_nxt;
            line_prev_r <= irq_line;
            prio_r <= prio_nxt;
        end
    end

    // outputs lag state by one cycle; stale request after entry
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_req_r <= 1'b0;
            irq_num_r <= '0;
            irq_prio_r <= '0;
            tick_exc_r <= 1'b0;
        end
        else
        begin
            irq_req_r <= preempt;
            irq_num_r <= cand.num;
            irq_prio_r <= cand.prio;
            tick_exc_r <= tick_stat.wrap_event & tick_cfg.inten;
        end
    end

    assign irq_req = irq_req_r;
    assign irq_req_num = irq_num_r;
    assign irq_req_prio = irq_prio_r;
    assign tick_exc_req = tick_exc_r;

endmodule
`default_nettype wire

// *** dv/ctirq_monitor.sv ***
/*
 checker for the tick timer and interrupt pending block.
 assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module ctirq_monitor
#(
    parameter int unsigned ADDR_W = 12
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [ctirq_pkg::NUM_IRQ-1:0] irq_line,
    input wire logic dbg_halt,
    input wire logic ref_tick,
    input wire logic handler_enter,
    input wire logic handler_return,
    input wire logic [ctirq_pkg::NUM_W-1:0] handler_num,
    input wire logic irq_req,
    input wire logic [ctirq_pkg::NUM_W-1:0] irq_req_num,
    input wire logic [ctirq_pkg::PRIO_W-1:0] irq_req_prio,
    input wire logic tick_exc_req
);
    default clocking mon_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    slverr_access_a: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    ready_a: assert property (psel |-> pready)
        else $error("wait state inserted");
    unmapped_zero_a: assert property (psel && penable && !pwrite
        && pslverr |-> prdata == 32'h00000000)
        else $error("refused read returned data");
    // readback must match the request outputs of the setup cycle
    sel_read_a: assert property (psel && !penable && !pwrite
        && paddr[7:0] == ctirq_pkg::OFS_SELECT ##1 penable
        |-> prdata[31] == $past(irq_req) && prdata[4:0] == $past(irq_req_num)
        && prdata[10:8] == $past(irq_req_prio))
        else $error("selection readback mismatch");
    entry_hides_a: assert property (handler_enter && irq_req
        && handler_num == irq_req_num |-> ##2
        !(irq_req && irq_req_num == $past(handler_num, 2)))
        else $error("entered interrupt still requested");
    exc_pulse_a: assert property (tick_exc_req |=> !tick_exc_req)
        else $error("tick exception too long");
    // six cycles drain any event already in flight
    halt_quiet_a: assert property (dbg_halt [*6] |-> !tick_exc_req)
        else $error("tick exception while halted");
    num_range_a: assert property (irq_req |-> irq_req_num < 5'h1D)
        else $error("request for missing line");

    req_seen_c: cover property ($rose(irq_req));
    exc_seen_c: cover property (tick_exc_req);
    refused_c: cover property (pslverr);
    return_c: cover property (handler_return);
endmodule
`default_nettype wire

// *** dv/ctirq_periph.sv ***
/*
 peripheral stand-in driving the interrupt request lines.
 assumes bench commands change just after a rising pclk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ctirq_periph
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [ctirq_pkg::NUM_IRQ-1:0] lvl_req,
    input wire logic [ctirq_pkg::NUM_IRQ-1:0] pulse_req,
    input wire logic [3:0] pulse_len,
    output logic [ctirq_pkg::NUM_IRQ-1:0] irq_line
);
    logic [ctirq_pkg::NUM_IRQ-1:0] pulse_r;
    logic [3:0] cnt_r;
    // level kept until the bench, acting as handler, drops it
    assign irq_line = lvl_req | pulse_r;
    // pulse width of at least one full cycle, longer when asked
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pulse_r <= '0;
            cnt_r <= 4'h0;
        end
        else if (|pulse_req)
        begin
            pulse_r <= pulse_req;
            cnt_r <= pulse_len;
        end
        else if (cnt_r > 4'h1)
            cnt_r <= cnt_r - 4'h1;
        else
            pulse_r <= '0;
    end
endmodule
`default_nettype wire

// *** dv/tb_core_tick_timer_and_irq_pending.sv ***
/*
 self-checking bench: apb register tasks, tick and interrupt tests.
 assumes package and peripheral model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_core_tick_timer_and_irq_pending;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, rd2, ex;
    logic pready, pslverr, irq_req, tick_exc_req, err;
    logic [4:0] irq_req_num;
    logic [2:0] irq_req_prio;
    logic [28:0] irq_line;
    logic [28:0] lvl_req = 29'h0;
    logic [28:0] pulse_req = 29'h0;
    logic [3:0] pulse_len = 4'h1;
    logic dbg_halt = 1'b0;
    logic ref_tick = 1'b0;
    logic handler_enter = 1'b0;
    logic handler_return = 1'b0;
    logic [4:0] handler_num = 5'h00;
    int mismatches = 0;
    int tests_run = 0;
    int exc_cnt = 0;

    ctirq_top #(.ADDR_W(12)) dut_u
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq_line(irq_line),
        .dbg_halt(dbg_halt), .ref_tick(ref_tick),
        .handler_enter(handler_enter), .handler_return(handler_return),
        .handler_num(handler_num), .irq_req(irq_req),
        .irq_req_num(irq_req_num), .irq_req_prio(irq_req_prio),
        .tick_exc_req(tick_exc_req)
    );
    ctirq_periph per_u
    (
        .pclk(pclk), .presetn(presetn), .lvl_req(lvl_req),
        .pulse_req(pulse_req), .pulse_len(pulse_len), .irq_line(irq_line)
    );

    always #2 pclk = ~pclk;
    always
    begin
        repeat (9) @(posedge pclk);
        ref_tick <= ~ref_tick;
    end
    always @(posedge pclk)
        if (tick_exc_req === 1'b1)
            exc_cnt++;

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
        input string what);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what,
                seen, exp);
        end
    endtask
    // waits on pready, no fixed latency assumed
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {4'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
        input string what);
        apb(1'b0, a, 32'h0);
        chk(rd, e, what);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic hnd(input logic ent, input logic [4:0] n);
        handler_enter <= ent;
        handler_return <= ~ent;
        handler_num <= n;
        @(posedge pclk);
        handler_enter <= 1'b0;
        handler_return <= 1'b0;
        idle(2);
    endtask
    task automatic pls(input logic [28:0] m);
        pulse_req <= m;
        @(posedge pclk);
        pulse_req <= 29'h0;
        idle(3);
    endtask

    initial
    begin
        idle(2);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(8'h00, 32'h0, "ctrl reset");
        rdc(8'h04, 32'h0, "reload reset");
        rdc(8'h20, 32'h1FFFFFFF, "level reset");
        apb(1'b0, 8'h30, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped");
        $display("test reset done");
        dbg_halt <= 1'b1;
        apb(1'b1, 8'h04, 32'h3);
        apb(1'b1, 8'h00, 32'h7);
        apb(1'b1, 8'h08, 32'hABCD);
        rdc(8'h08, 32'h0, "halted current");
        rdc(8'h00, 32'h7, "ctrl fields");
        exc_cnt = 0;
        dbg_halt <= 1'b0;
        idle(40);
        dbg_halt <= 1'b1;
        idle(8);
        chk(exc_cnt, 32'hA, "wraps in 40 steps");
        rdc(8'h00, 32'h10007, "flag set");
        rdc(8'h00, 32'h7, "flag read clear");
        dbg_halt <= 1'b0;
        idle(8);
        dbg_halt <= 1'b1;
        idle(6);
        exc_cnt = 0;
        apb(1'b1, 8'h08, 32'h0);
        idle(6);
        chk(exc_cnt, 32'h0, "no exc on write");
        rdc(8'h08, 32'h0, "write clears");
        rdc(8'h00, 32'h7, "write clears flag");
        dbg_halt <= 1'b0;
        idle(2);
        apb(1'b1, 8'h04, 32'h0);
        idle(8);
        rdc(8'h08, 32'h0, "zero reload stops");
        idle(4);
        rdc(8'h08, 32'h0, "still stopped");
        apb(1'b1, 8'h04, 32'hFFFFFF);
        apb(1'b1, 8'h08, 32'h0);
        idle(3);
        apb(1'b0, 8'h08, 32'h0);
        rd2 = rd;
        apb(1'b0, 8'h08, 32'h0);
        chk(rd2 - rd, 32'h3, "live value");
        chk(rd2 & 32'hFF000000, 32'h0, "counter width");
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b0, 8'h08, 32'h0);
        rd2 = rd;
        idle(33);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd2 - rd, 32'h2, "ref steps");
        $display("test tick done");
        apb(1'b1, 8'h10, 32'h001000A8);
        lvl_req <= 29'h20;
        idle(3);
        rdc(8'h14, 32'h20, "level pends");
        rdc(8'h2C, 32'h80000005, "select level");
        apb(1'b1, 8'h18, 32'h20);
        rdc(8'h14, 32'h20, "clear ignored");
        hnd(1'b1, 5'h05);
        rdc(8'h1C, 32'h20, "entry active");
        rdc(8'h14, 32'h0, "entry unpends");
        hnd(1'b0, 5'h05);
        rdc(8'h14, 32'h20, "return repends");
        hnd(1'b1, 5'h05);
        lvl_req <= 29'h0;
        hnd(1'b0, 5'h05);
        rdc(8'h14, 32'h0, "return inactive");
        rdc(8'h1C, 32'h0, "return idle");
        apb(1'b1, 8'h14, 32'h20);
        apb(1'b1, 8'h18, 32'h20);
        rdc(8'h14, 32'h0, "clear line low");
        $display("test level done");
        apb(1'b1, 8'h20, 32'h1FFFFF7F);
        pulse_len <= 4'h3;
        pls(29'h80);
        rdc(8'h14, 32'h80, "edge pends");
        hnd(1'b1, 5'h07);
        pulse_len <= 4'h1;
        pls(29'h80);
        rdc(8'h14, 32'h80, "pulse in handler");
        rdc(8'h1C, 32'h80, "act and pend");
        apb(1'b1, 8'h18, 32'h80);
        rdc(8'h14, 32'h0, "clear keeps active");
        rdc(8'h1C, 32'h80, "active only");
        pls(29'h80);
        hnd(1'b0, 5'h07);
        rdc(8'h14, 32'h80, "pending on return");
        hnd(1'b1, 5'h07);
        hnd(1'b0, 5'h07);
        rdc(8'h14, 32'h0, "no pulse inactive");
        pls(29'h80);
        apb(1'b1, 8'h18, 32'h80);
        rdc(8'h14, 32'h0, "clear pulse");
        $display("test pulse done");
        apb(1'b1, 8'h24, 32'h3);
        apb(1'b1, 8'h14, 32'h100000);
        apb(1'b1, 8'h48, 32'h40000);
        for (int p = 0; p < 8; p++)
        begin
            apb(1'b1, 8'h40, 32'(p) << 12);
            ex = (p <= 4) ? 32'h80000003 | (32'(p) << 8) : 32'h80000414;
            idle(2);
            rdc(8'h2C, ex, "winner");
            chk({27'h0, irq_req_num}, {27'h0, ex[4:0]}, "win port");
        end
        hnd(1'b1, 5'h03);
        idle(2);
        chk({31'h0, irq_req}, 32'h1, "preempt by group");
        apb(1'b1, 8'h28, 32'h3);
        idle(2);
        chk({31'h0, irq_req}, 32'h0, "same group waits");
        hnd(1'b0, 5'h03);
        $display("test priority done");
        close_out();
    end

    // whole run is under 400 cycles
    initial
    begin
        idle(20000);
        mismatches++;
        close_out();
    end
endmodule

bind ctirq_top ctirq_monitor #(.ADDR_W(ADDR_W)) mon_u
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_line(irq_line),
    .dbg_halt(dbg_halt), .ref_tick(ref_tick),
    .handler_enter(handler_enter), .handler_return(handler_return),
    .handler_num(handler_num), .irq_req(irq_req),
    .irq_req_num(irq_req_num), .irq_req_prio(irq_req_prio),
    .tick_exc_req(tick_exc_req)
);
`default_nettype wire
